/* File: tb_top.sv */
// Self-checking bench for the TFT timing and pixel block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import tlc_pkg::*;
	logic clk_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, word = 0, q, hrdata, r;
	logic hready, hresp, take, fs, ls, pclk, de, line_end_strobe;
	logic [23:0] pins, oe, gpio, gpoe;
	logic [15:0] m_len, m_act, m_hsw, m_lines, m_alines, m_vsw;
	logic [191:0] m_px;
	logic [15:0] pal [256];
	logic [7:0] modes [10] = '{8'h01, 8'h83, 8'h95, 8'h05, 8'h17, 8'h87, 8'h89, 8'h29, 8'h0B, 8'h5B};
	logic [1:0] dv;
	time t0;
	int seed = 70, miscompares = 0, compares = 0, takes = 0;

	always #4 clk_i = ~clk_i;

	// Word consumption pulses, counted per displayed line
	always @(posedge clk_i) if (take === 1'b1) takes <= takes + 1;

	tlc_timing i_tlc_timing (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.word_i(word), .word_take_o(take), .frame_sync_o(fs), .line_sync_o(ls),
		.pixel_clock_o(pclk), .display_data_enable_o(de), .line_end_strobe_o(line_end_strobe),
		.video_data_pins_o(pins), .video_data_pins_oe_o(oe));
	tlc_panel_model i_tlc_panel_model (.pixel_clock_i(pclk), .frame_sync_i(fs),
		.line_sync_i(ls), .de_i(de), .pins_i(pins), .line_len_o(m_len), .act_o(m_act),
		.hs_w_o(m_hsw), .lines_o(m_lines), .act_lines_o(m_alines), .vs_w_o(m_vsw), .px_o(m_px));

	// ------------------------------------------------------------
	// Bus cycles, comparison and expected pixels
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// Single word transfer; no wait count is assumed, the watchdog ends a hang
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic [23:0] used(input logic [7:0] c);
		if (c[3:1] >= 3'h5) return MASK_24;
		return c[7] ? MASK_565 : MASK_5551;
	endfunction
	function automatic logic [23:0] map16(input logic [15:0] c, input logic f);
		if (f) return {c[15:11], 3'h0, c[10:5], 2'h0, c[4:0], 3'h0};
		return {c[15:11], c[0], 2'h0, c[10:6], c[0], 2'h0, c[5:1], c[0], 2'h0};
	endfunction
	// Every slot of a line reuses the same word, so slot k picks within one word
	function automatic logic [23:0] exp_pix(input logic [7:0] c, input logic [31:0] w, input int k);
		logic [23:0] v;
		int n;
		int s;
		n = 1 << c[3:1];
		if (c[3:1] >= 3'h5) v = c[6] ? w[31:8] : w[23:0];
		else if (c[3:1] == 3'h4) v = map16((k[0] ^ c[5]) ? w[15:0] : w[31:16], c[7]);
		else begin
			s = k % (32 / n);
			if (c[4]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
			v = map16(pal[(w >> (32 - n * (s + 1))) & ((1 << n) - 1)], c[7]);
		end
		return (v & used(c)) | (gpio & ~used(c));
	endfunction
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		ahb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl_reset", q, 32'h0);
		ahb(1'b0, 12'h024, 32'h0);
		chk("unmapped", q, 32'h0);
		ahb(1'b1, OFS_DIV, 32'hFFFFFFFF);
		ahb(1'b0, OFS_DIV, 32'h0);
		chk("div_max", q, 32'h3FF);
		chk("idle_link", {hresp, fs, ls, pclk, de}, 32'h0);
		$display("test reset_regs done");
		// Random geometry; the first pass uses the fastest divider
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			dv = (i == 0) ? 2'h0 : r[18:17];
			ahb(1'b1, OFS_HSIZE, {29'h0, r[8:6]});
			ahb(1'b1, OFS_HPORCH, {14'h0, r[5:4], 6'h0, r[3:2], 6'h0, r[1:0]});
			ahb(1'b1, OFS_VSIZE, {30'h0, r[16:15]});
			ahb(1'b1, OFS_VPORCH, {14'h0, r[14:13], 6'h0, r[12:11], 6'h0, r[10:9]});
			ahb(1'b1, OFS_DIV, {30'h0, dv});
			ahb(1'b1, OFS_CTRL, 32'h7);
			repeat (3) @(posedge fs);
			@(posedge pclk);
			t0 = $time;
			@(posedge pclk);
			chk("pclk_period", 32'(($time - t0) / 8), 2 * (dv + 1));
			chk("line_len", m_len, r[1:0] + r[3:2] + r[5:4] + r[8:6] + 4);
			chk("act_px", m_act, r[8:6] + 1);
			chk("hsync_w", m_hsw, r[1:0] + 1);
			chk("lines", m_lines, r[10:9] + r[12:11] + r[14:13] + r[16:15] + 4);
			chk("act_lines", m_alines, r[16:15] + 1);
			chk("vsync_w", m_vsw, r[10:9] + 1);
			ahb(1'b1, OFS_CTRL, 32'h0);
			$display("test timing %0d done", i);
		end
		// Palette with random colours, then one line per pixel format
		for (int i = 0; i < 256; i++) begin
			pal[i] = 16'($random(seed));
			ahb(1'b1, 12'h400 + 12'(4 * i), {16'h0000, pal[i]});
		end
		ahb(1'b1, OFS_HSIZE, 32'h7);
		ahb(1'b1, OFS_HPORCH, 32'h0);
		ahb(1'b1, OFS_VSIZE, 32'h0);
		ahb(1'b1, OFS_VPORCH, 32'h0);
		ahb(1'b1, OFS_DIV, 32'h0);
		foreach (modes[j]) begin
			word <= $random(seed);
			gpio = 24'($random(seed));
			gpoe = 24'($random(seed));
			ahb(1'b1, OFS_GPIO_OUT, {8'h00, gpio});
			ahb(1'b1, OFS_GPIO_OE, {8'h00, gpoe});
			ahb(1'b1, OFS_CTRL, {24'h0, modes[j]});
			@(posedge de);
			takes = 0;
			@(negedge de);
			@(posedge clk_i);
			for (int k = 0; k < 8; k++) begin
				chk("pixel", m_px[24 * k +: 24], exp_pix(modes[j], word, k));
			end
			chk("pixel_order", m_px[23:0], exp_pix(modes[j], word, 0));
			chk("pins_blank", pins, gpio & ~used(modes[j]));
			chk("pin_enable", oe, used(modes[j]) | gpoe);
			chk("line_end", {31'h0, line_end_strobe}, 32'h1);
			@(posedge clk_i);
			chk("word_take", takes, (modes[j][3:1] >= 3'h2) ? (1 << modes[j][3:1]) / 4 : 1);
			ahb(1'b1, OFS_CTRL, 32'h0);
			$display("test format %h done", modes[j]);
		end
		summarize();
	end

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire

/* File: tlc_panel_model.sv */
// Panel-side model of the video link: samples on pixel clock rises and measures frames
`timescale 1ns/100ps
`default_nettype none
module tlc_panel_model (
	input wire logic pixel_clock_i,
	input wire logic frame_sync_i,
	input wire logic line_sync_i,
	input wire logic de_i,
	input wire logic [23:0] pins_i,
	output logic [15:0] line_len_o,
	output logic [15:0] act_o,
	output logic [15:0] hs_w_o,
	output logic [15:0] lines_o,
	output logic [15:0] act_lines_o,
	output logic [15:0] vs_w_o,
	output logic [191:0] px_o
);
	logic [15:0] pc = 0, ac = 0, hw = 0, ln = 0, al = 0, vw = 0;
	logic ls_q = 0, fs_q = 0;

	// A panel only listens; sync edges close the figures of the line or frame just ended
	always @(posedge pixel_clock_i) begin
		ls_q <= line_sync_i;
		fs_q <= frame_sync_i;
		if (line_sync_i && !ls_q) begin
			line_len_o <= pc;
			hs_w_o <= hw;
			pc <= 16'h0001;
			ac <= 16'h0000;
			hw <= 16'h0001;
			ln <= ln + 16'h0001;
			// Blank lines keep the last active count, so porch lines do not hide it
			if (ac != 0) begin
				act_o <= ac;
				al <= al + 16'h0001;
			end
			if (frame_sync_i && !fs_q) begin
				lines_o <= ln;
				act_lines_o <= al;
				vs_w_o <= vw;
				ln <= 16'h0001;
				al <= 16'h0000;
				vw <= 16'h0001;
			end else if (frame_sync_i) begin
				vw <= vw + 16'h0001;
			end
		end else begin
			pc <= pc + 16'h0001;
			if (line_sync_i) begin
				hw <= hw + 16'h0001;
			end
			if (de_i) begin
				px_o[24 * ac[2:0] +: 24] <= pins_i;
				ac <= ac + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tlc_pix_pick.sv */
// Picks one pixel out of a frame-buffer word by depth, slot and swaps
`timescale 1ns/100ps
`default_nettype none
module tlc_pix_pick (
	input wire logic [31:0] word_i,
	input wire logic [4:0] slot_i,
	input wire logic [2:0] bpp_i,
	input wire logic byte_swap_i,
	input wire logic halfword_swap_i,
	input wire logic place_i,
	output logic [23:0] pix_o
);
	import tlc_pkg::*;
	logic [31:0] sw;
	logic [31:0] sh;
	logic [4:0] shamt;

	// Swap first, then the wanted slot is shifted to the top
	always_comb begin
		if (byte_swap_i && bpp_i <= BPP_8) begin
			sw = {word_i[7:0], word_i[15:8], word_i[23:16], word_i[31:24]}; // R16 R17
		end else if (halfword_swap_i && bpp_i == BPP_16) begin
			sw = {word_i[15:0], word_i[31:16]}; // R13
		end else begin
			sw = word_i;
		end
		shamt = 5'(slot_i << bpp_i);
		sh = sw << shamt; // R18
	end

	// Depth select; 24 bpp ignores the padding byte
	always_comb begin
		case (bpp_i)
			BPP_1: pix_o = {23'h0, sh[31]};
			BPP_2: pix_o = {22'h0, sh[31:30]}; // R18
			BPP_4: pix_o = {20'h0, sh[31:28]}; // R17
			BPP_8: pix_o = {16'h0, sh[31:24]}; // R16
			BPP_16: pix_o = {8'h0, sh[31:16]}; // R13
			BPP_24: pix_o = place_i ? word_i[31:8] : word_i[23:0]; // R10 R11
			default: pix_o = place_i ? word_i[31:8] : word_i[23:0]; // R10 R11
		endcase
	end
endmodule
`default_nettype wire

/* File: tlc_pkg.sv */
// Shared constants and types of the TFT timing and pixel block
package tlc_pkg;
	// ----------------------------------------------------------------
	// Register map (byte offsets within the slave window)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_HSIZE = 12'h004;
	localparam logic [11:0] OFS_HPORCH = 12'h008;
	localparam logic [11:0] OFS_VSIZE = 12'h00C;
	localparam logic [11:0] OFS_VPORCH = 12'h010;
	localparam logic [11:0] OFS_DIV = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_GPIO_OUT = 12'h01C;
	localparam logic [11:0] OFS_GPIO_OE = 12'h020;
	localparam logic [1:0] PAL_SEL = 2'h1;
	// ----------------------------------------------------------------
	// Field layout of display_control_one
	// ----------------------------------------------------------------
	localparam int CTRL_W = 8;
	localparam int CB_EN = 0;
	localparam int CB_BPP = 1;
	localparam int CB_BSWAP = 4;
	localparam int CB_HSWAP = 5;
	localparam int CB_PLACE = 6;
	localparam int CB_F565 = 7;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 11;
	localparam int POR_W = 8;
	localparam int DIV_W = 10;
	localparam int VD_W = 24;
	localparam int PAL_D = 256;
	localparam int PB_PW = 0;
	localparam int PB_BP = 8;
	localparam int PB_FP = 16;
	// ----------------------------------------------------------------
	// Pixel depth codes and pin masks
	// ----------------------------------------------------------------
	localparam logic [2:0] BPP_1 = 3'h0;
	localparam logic [2:0] BPP_2 = 3'h1;
	localparam logic [2:0] BPP_4 = 3'h2;
	localparam logic [2:0] BPP_8 = 3'h3;
	localparam logic [2:0] BPP_16 = 3'h4;
	localparam logic [2:0] BPP_24 = 3'h5;
	localparam logic [23:0] MASK_24 = 24'hFFFFFF;
	localparam logic [23:0] MASK_565 = 24'hF8FCF8;
	localparam logic [23:0] MASK_5551 = 24'hFCFCFC;
	// Phases of a line and of a frame, in display order
	typedef enum logic [1:0] {
		PH_SYNC = 2'b00,
		PH_BACK = 2'b01,
		PH_ACT = 2'b10,
		PH_FRONT = 2'b11
	} tlc_phase_e;
endpackage

/* File: tlc_timing.sv */
// TFT timing generator, palette and video pin drive behind AHB-Lite
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: Generate frame sync, line sync, pixel clock, data enable, line end from registers.
// R2: Every frame sync pulse starts a new frame at the top row.
// R3: Horizontal size field plus one active pixels per displayed line.
// R4: Vertical size field plus one active lines per frame.
// R5: Pixel clock is bus clock over twice (divider plus one); divider up to 1023.
// R6: Divider value zero is legal and gives the fastest pixel clock.
// R7: Line and frame lengths are the four phase fields each plus one.
// R8: 1/2/4/8 bpp go through palette; 16 and 24 bpp are direct.
// R9: Palettised pixels are translated through a 256-entry palette.
// R10: 24 bpp, placement clear: pixel in bits 23..0, top byte ignored.
// R11: 24 bpp, placement set: pixel in bits 31..8, low byte ignored.
// R12: 24 bpp: red to pins 23..16, green 15..8, blue 7..0.
// R13: 16 bpp: first pixel from high half, low half when halfword swap on.
// R14: 5:6:5 red 23..19, green 15..10, blue 7..3; intensity to 18, 10, 2.
// R15: Video pins unused by the format serve as general-purpose outputs.
// R16: 8 bpp: bytes from 31..24 down; byte swap reverses byte order.
// R17: 4 bpp: nibbles 31..28 down; byte swap reverses bytes, keeps nibbles.
// R18: 2 bpp: sixteen pixels from bits 31..30 down to 1..0.
// R19: Palette entries are 16 bits, 5:6:5 or 5:5:5 plus intensity by select.
// R20: Data enable only in active pixels of active lines.
// R21: Line sync once per line, frame sync once per frame, widths pulse field plus one.
module tlc_timing (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [31:0] word_i,
	output logic word_take_o,
	output logic frame_sync_o,
	output logic line_sync_o,
	output logic pixel_clock_o,
	output logic display_data_enable_o,
	output logic line_end_strobe_o,
	output logic [tlc_pkg::VD_W-1:0] video_data_pins_o,
	output logic [tlc_pkg::VD_W-1:0] video_data_pins_oe_o
);
	import tlc_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Last count of a phase, shared by the line and frame counters
	function automatic logic [CNT_W-1:0] phase_last(input tlc_phase_e ph,
		input logic [POR_W-1:0] pw, input logic [POR_W-1:0] bp,
		input logic [CNT_W-1:0] sz, input logic [POR_W-1:0] fp);
		case (ph)
			PH_SYNC: phase_last = CNT_W'(pw);
			PH_BACK: phase_last = CNT_W'(bp);
			PH_ACT: phase_last = sz;
			PH_FRONT: phase_last = CNT_W'(fp);
			default: phase_last = '0;
		endcase
	endfunction

	// 16-bit colour onto the pins, for palette entries and direct pixels
	function automatic logic [VD_W-1:0] map16(input logic [15:0] e, input logic f565);
		if (f565) begin
			map16 = {e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0}; // R14
		end else begin
			map16 = {e[15:11], e[0], 2'h0, e[10:6], e[0], 2'h0, e[5:1], e[0], 2'h0}; // R14
		end
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_ff;
	logic [CNT_W-1:0] hsize_ff;
	logic [CNT_W-1:0] vsize_ff;
	logic [23:0] hporch_ff;
	logic [23:0] vporch_ff;
	logic [DIV_W-1:0] div_ff;
	logic [VD_W-1:0] gpio_out_ff;
	logic [VD_W-1:0] gpio_oe_ff;
	logic [15:0] pal_mem [PAL_D];
	logic wr_pend_ff;
	logic [11:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_val;
	tlc_phase_e hph_ff;
	tlc_phase_e vph_ff;
	logic [CNT_W-1:0] hcnt_ff;
	logic [CNT_W-1:0] vcnt_ff;
	logic addr_ok;
	logic [11:0] ra;
	logic en;
	logic [2:0] bpp;
	logic f565;

	assign addr_ok = hsel_i && htrans_i[1] && hready_i;
	assign ra = {haddr_i[11:2], 2'h0};
	assign en = ctrl_ff[CB_EN];
	assign bpp = ctrl_ff[CB_BPP +: 3];
	assign f565 = ctrl_ff[CB_F565];
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_ff;

	// Address phase capture; every transfer finishes with no wait state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
		end else begin
			wr_pend_ff <= addr_ok && hwrite_i;
			wr_addr_ff <= ra;
		end
	end

	// Control register writes in the data phase
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= CTRL_RST;
			hsize_ff <= '0;
			vsize_ff <= '0;
			hporch_ff <= '0;
			vporch_ff <= '0;
			div_ff <= '0;
			gpio_out_ff <= '0;
			gpio_oe_ff <= '0;
		end else if (wr_pend_ff) begin
			case (wr_addr_ff)
				OFS_CTRL: ctrl_ff <= hwdata_i[CTRL_W-1:0];
				OFS_HSIZE: hsize_ff <= hwdata_i[CNT_W-1:0];
				OFS_HPORCH: hporch_ff <= hwdata_i[23:0];
				OFS_VSIZE: vsize_ff <= hwdata_i[CNT_W-1:0];
				OFS_VPORCH: vporch_ff <= hwdata_i[23:0];
				OFS_DIV: div_ff <= hwdata_i[DIV_W-1:0]; // R5 R6
				OFS_GPIO_OUT: gpio_out_ff <= hwdata_i[VD_W-1:0];
				OFS_GPIO_OE: gpio_oe_ff <= hwdata_i[VD_W-1:0];
				default: ;
			endcase
		end
	end

	// Palette store; memory is not reset, software loads it before use
	always_ff @(posedge clk_i) begin
		if (wr_pend_ff && wr_addr_ff[11:10] == PAL_SEL) begin
			pal_mem[wr_addr_ff[9:2]] <= hwdata_i[15:0]; // R9 R19
		end
	end

	// Read mux; a write still in its data phase is forwarded to avoid stale reads
	always_comb begin
		case (ra)
			OFS_CTRL: rd_val = 32'(ctrl_ff);
			OFS_HSIZE: rd_val = 32'(hsize_ff);
			OFS_HPORCH: rd_val = 32'(hporch_ff);
			OFS_VSIZE: rd_val = 32'(vsize_ff);
			OFS_VPORCH: rd_val = 32'(vporch_ff);
			OFS_DIV: rd_val = 32'(div_ff);
			OFS_STATUS: rd_val = 32'({hph_ff, vph_ff, vcnt_ff});
			OFS_GPIO_OUT: rd_val = 32'(gpio_out_ff);
			OFS_GPIO_OE: rd_val = 32'(gpio_oe_ff);
			default: rd_val = (ra[11:10] == PAL_SEL) ? 32'(pal_mem[ra[9:2]]) : 32'h0;
		endcase
		if (wr_pend_ff && wr_addr_ff == ra && ra != OFS_STATUS) begin
			rd_val = hwdata_i;
		end
	end

	// Read data is registered at the address phase, ready in the data phase
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_ff <= 32'h0;
		end else if (addr_ok && !hwrite_i) begin
			hrdata_ff <= rd_val;
		end
	end

	// ----------------------------------------------------------------
	// Pixel clock divider
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt_ff;
	logic pclk_ff;
	logic tick;

	// Toggle every divider+1 bus clocks; a full period is twice that
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_ff <= '0;
			pclk_ff <= 1'b0;
		end else if (!en) begin
			div_cnt_ff <= '0;
			pclk_ff <= 1'b0;
		end else if (div_cnt_ff == div_ff) begin
			div_cnt_ff <= '0; // R5 R6
			pclk_ff <= ~pclk_ff; // R5
		end else begin
			div_cnt_ff <= DIV_W'(div_cnt_ff + 10'h001);
		end
	end

	// Timing advances as the clock falls, so the panel samples settled data
	assign tick = en && pclk_ff && div_cnt_ff == div_ff;
	assign pixel_clock_o = pclk_ff;

	// ----------------------------------------------------------------
	// Line and frame sequencing
	// ----------------------------------------------------------------
	tlc_phase_e nxt_hph;
	tlc_phase_e nxt_vph;
	logic [CNT_W-1:0] nxt_hcnt;
	logic [CNT_W-1:0] nxt_vcnt;
	logic nxt_den;
	logic run_ff;

	// Next position: sync, back porch, active, front porch, then wrap
	always_comb begin
		nxt_hph = hph_ff;
		nxt_vph = vph_ff;
		nxt_hcnt = CNT_W'(hcnt_ff + 11'h001);
		nxt_vcnt = vcnt_ff;
		if (hcnt_ff == phase_last(hph_ff, hporch_ff[PB_PW +: POR_W],
			hporch_ff[PB_BP +: POR_W], hsize_ff, hporch_ff[PB_FP +: POR_W])) begin
			nxt_hcnt = '0; // R7 R3
			nxt_hph = tlc_phase_e'(2'(hph_ff + 2'h1));
			if (hph_ff == PH_FRONT) begin
				nxt_vcnt = CNT_W'(vcnt_ff + 11'h001);
				if (vcnt_ff == phase_last(vph_ff, vporch_ff[PB_PW +: POR_W],
					vporch_ff[PB_BP +: POR_W], vsize_ff, vporch_ff[PB_FP +: POR_W])) begin
					nxt_vcnt = '0; // R7 R4
					nxt_vph = tlc_phase_e'(2'(vph_ff + 2'h1)); // R2
				end
			end
		end
		// The first tick after enable shows the parked frame start instead of leaving it
		if (!run_ff) begin
			nxt_hph = hph_ff;
			nxt_vph = vph_ff;
			nxt_hcnt = hcnt_ff;
			nxt_vcnt = vcnt_ff; // R2
		end
		nxt_den = nxt_hph == PH_ACT && nxt_vph == PH_ACT; // R20
	end

	// Position counters; disabling parks the sequencer at the frame start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_ff <= 1'b0;
			hph_ff <= PH_SYNC;
			vph_ff <= PH_SYNC;
			hcnt_ff <= '0;
			vcnt_ff <= '0;
		end else if (!en) begin
			run_ff <= 1'b0;
			hph_ff <= PH_SYNC;
			vph_ff <= PH_SYNC;
			hcnt_ff <= '0;
			vcnt_ff <= '0;
		end else if (tick) begin
			run_ff <= 1'b1;
			hph_ff <= nxt_hph;
			vph_ff <= nxt_vph;
			hcnt_ff <= nxt_hcnt;
			vcnt_ff <= nxt_vcnt;
		end
	end

	// Sync, enable and line end follow the position taken at the same tick
	logic hs_ff;
	logic vs_ff;
	logic den_ff;
	logic line_end_strobe_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs_ff <= 1'b0;
			vs_ff <= 1'b0;
			den_ff <= 1'b0;
			line_end_strobe_ff <= 1'b0;
		end else if (!en) begin
			hs_ff <= 1'b0;
			vs_ff <= 1'b0;
			den_ff <= 1'b0;
			line_end_strobe_ff <= 1'b0;
		end else if (tick) begin
			hs_ff <= nxt_hph == PH_SYNC; // R1 R21
			vs_ff <= nxt_vph == PH_SYNC; // R1 R21 R2
			den_ff <= nxt_den; // R20
			line_end_strobe_ff <= nxt_hph == PH_FRONT && hph_ff == PH_ACT; // R1
		end
	end
	assign line_sync_o = hs_ff;
	assign frame_sync_o = vs_ff;
	assign display_data_enable_o = den_ff;
	assign line_end_strobe_o = line_end_strobe_ff;

	// ----------------------------------------------------------------
	// Word unpacking and pin drive
	// ----------------------------------------------------------------
	logic [4:0] slot_ff;
	logic [4:0] slot_last;
	logic take_ff;
	logic [23:0] pix;
	logic [VD_W-1:0] color;
	logic [VD_W-1:0] mask;
	logic [VD_W-1:0] vd_ff;
	logic [VD_W-1:0] vd_oe_ff;

	tlc_pix_pick u_pick (
		.word_i(word_i),
		.slot_i(slot_ff),
		.bpp_i(bpp),
		.byte_swap_i(ctrl_ff[CB_BSWAP]),
		.halfword_swap_i(ctrl_ff[CB_HSWAP]),
		.place_i(ctrl_ff[CB_PLACE]),
		.pix_o(pix)
	);

	// Slots per word are 32 >> depth code; 24 bpp has one
	assign slot_last = (bpp >= BPP_24) ? 5'h00 : 5'(6'h20 >> bpp) - 5'h01;

	// Colour and used-pin mask by depth and palette format
	always_comb begin
		if (bpp >= BPP_24) begin
			color = pix; // R12
			mask = MASK_24;
		end else begin
			if (bpp == BPP_16) begin
				color = map16(pix[15:0], f565); // R8 R14
			end else begin
				color = map16(pal_mem[pix[7:0]], f565); // R8 R9 R19
			end
			mask = f565 ? MASK_565 : MASK_5551;
		end
	end

	// Slot walk; a partly shown word at line end is still consumed
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_ff <= 5'h00;
			take_ff <= 1'b0;
		end else begin
			take_ff <= 1'b0;
			if (!en) begin
				slot_ff <= 5'h00;
			end else if (tick && nxt_den) begin
				if (slot_ff >= slot_last) begin
					slot_ff <= 5'h00;
					take_ff <= 1'b1; // R16 R17 R18
				end else begin
					slot_ff <= 5'(slot_ff + 5'h01);
				end
			end else if (tick && den_ff && slot_ff != 5'h00) begin
				slot_ff <= 5'h00;
				take_ff <= 1'b1;
			end
		end
	end
	assign word_take_o = take_ff;

	// Unused pins carry the general-purpose output value and enable
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vd_ff <= '0;
			vd_oe_ff <= '0;
		end else begin
			vd_oe_ff <= (en ? mask : '0) | gpio_oe_ff; // R15
			if (!en) begin
				vd_ff <= gpio_out_ff;
			end else if (tick) begin
				vd_ff <= ((nxt_den ? color : '0) & mask) | (gpio_out_ff & ~mask); // R15
			end
		end
	end
	assign video_data_pins_o = vd_ff;
	assign video_data_pins_oe_o = vd_oe_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic [DIV_W-1:0] half_ff;
	logic [CNT_W:0] pix_seen_ff;
	logic [CNT_W:0] lines_ff;
	logic [POR_W:0] hs_len_ff;
	logic tick_q_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_ff <= '0;
			pix_seen_ff <= '0;
			lines_ff <= '0;
			hs_len_ff <= '0;
			tick_q_ff <= 1'b0;
		end else begin
			tick_q_ff <= tick;
			// Parked at all ones while disabled, so the first enabled edge counts as zero
			if (!en) begin
				half_ff <= '1;
			end else begin
				half_ff <= (pclk_ff != $past(pclk_ff)) ? '0 : DIV_W'(half_ff + 10'h001);
			end
			if (hs_ff && !$past(hs_ff)) begin
				pix_seen_ff <= '0;
			end else if (tick_q_ff && den_ff) begin
				pix_seen_ff <= 12'(pix_seen_ff + 12'h001);
			end
			if (!en || (vs_ff && !$past(vs_ff))) begin
				lines_ff <= '0;
			end else if (!den_ff && $past(den_ff)) begin
				lines_ff <= 12'(lines_ff + 12'h001);
			end
			if (!hs_ff) begin
				hs_len_ff <= '0;
			end else if (tick_q_ff) begin
				hs_len_ff <= 9'(hs_len_ff + 9'h001);
			end
		end
	end

	sequence s_tick_px;
		tick && nxt_den && $stable(ctrl_ff);
	endsequence

	property p_pclk_half;
		en && $stable(div_ff) && $changed(pclk_ff) && $past(en) |-> half_ff == div_ff;
	endproperty
	a_pclk_half: assert property (p_pclk_half) else $error("pixel clock half period wrong"); // R5 R6

	property p_den_active;
		den_ff |-> hph_ff == PH_ACT && vph_ff == PH_ACT;
	endproperty
	a_den_active: assert property (p_den_active) else $error("enable outside active area"); // R20

	property p_line_pixels;
		$rose(line_end_strobe_ff) && vph_ff == PH_ACT && $stable(hsize_ff) |->
			pix_seen_ff == 12'(hsize_ff) + 12'h001;
	endproperty
	a_line_pixels: assert property (p_line_pixels) else $error("active pixel count wrong"); // R3

	property p_frame_lines;
		$rose(vs_ff) && $past(lines_ff) != '0 |->
			$past(lines_ff) == 12'(vsize_ff) + 12'h001;
	endproperty
	a_frame_lines: assert property (p_frame_lines) else $error("active line count wrong"); // R4

	property p_hs_width;
		$fell(hs_ff) && en |-> hs_len_ff == 9'(hporch_ff[PB_PW +: POR_W]) + 9'h001;
	endproperty
	a_hs_width: assert property (p_hs_width) else $error("line sync width wrong"); // R21

	property p_vs_top;
		$rose(vs_ff) |-> vcnt_ff == '0 && hph_ff == PH_SYNC;
	endproperty
	a_vs_top: assert property (p_vs_top) else $error("frame sync not at frame start"); // R2

	property p_take_pulse;
		take_ff |=> !take_ff;
	endproperty
	a_take_pulse: assert property (p_take_pulse) else $error("word take longer than one cycle"); // R16

	property p_24_low;
		s_tick_px and (bpp == BPP_24 && !ctrl_ff[CB_PLACE] && gpio_out_ff == '0)
			|=> vd_ff == $past(word_i[23:0]);
	endproperty
	a_24_low: assert property (p_24_low) else $error("24 bpp low placement wrong"); // R10 R12

	property p_24_high;
		s_tick_px and (bpp == BPP_24 && ctrl_ff[CB_PLACE])
			|=> vd_ff == $past(word_i[31:8]);
	endproperty
	a_24_high: assert property (p_24_high) else $error("24 bpp high placement wrong"); // R11

	property p_oe_mask;
		en && bpp == BPP_16 && f565 && $stable(ctrl_ff) && $stable(gpio_oe_ff) |=>
			vd_oe_ff == (MASK_565 | gpio_oe_ff);
	endproperty
	a_oe_mask: assert property (p_oe_mask) else $error("pin enable mask wrong"); // R15 R14
endmodule
`default_nettype wire
